// >>> adc_sequencing_control.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
`include "conv_defines.svh"
// Function
// RULE1: three channel bits pick one of eight analog inputs, code n selects input n
// RULE2: writing one to start bit launches one conversion on selected channel
// RULE3: hardware clears start bit at completion; it reads one while busy
// RULE4: done flag set when results are stored; only software clears it
// RULE5: interrupt request while done flag and converter interrupt enable are both one
// RULE6: full scale gives 3ff, at or below low reference gives 000, linear between
// RULE7: result bits 9:2 in high register, bits 1:0 in low register
// RULE8: conversion lasts 11 converter clocks: one sample, ten bit decisions
// RULE9: five bit prescaler; zero divides by 64, else by twice value
// RULE10: enable bit keeps converter active; clear means low power standby
// RULE11: software waits 4 us after enabling before first start
// RULE12: pseudo idle bit plus start halts the cpu, peripherals keep running
// RULE13: in pseudo idle only the end of conversion interrupt wakes the cpu
// RULE14: other interrupts during pseudo idle conversion stay pending until finish
// RULE15: each pin config bit routes that pin to the analog multiplexer
// RULE16: unused prescaler and low result bits read indeterminate; never write ones
// RULE17: high result register read only, reset zero
// RULE18: low result register read only, reset zero
// RULE19: converter interrupt forwarded only when global enable is one
// RULE20: both results written with done flag set; software writes ignored
module adc_sequencing_control (
   input  wire logic        clock_i,            // 250 MHz system clock
   input  wire logic        srst_i,             // sync reset, active high
   input  wire logic        wb_cyc_i,           // wishbone cycle
   input  wire logic        wb_stb_i,           // wishbone strobe
   input  wire logic        wb_we_i,            // wishbone write
   input  wire logic [7:0]  wb_adr_i,           // register index
   input  wire logic [3:0]  wb_sel_i,           // byte enables
   input  wire logic [31:0] wb_dat_i,           // write data
   output logic      [31:0] wb_dat_o,           // read data
   output logic             wb_ack_o,           // acknowledge
   input  wire logic [9:0]  converter_input_i,  // quantised level of selected input
   input  wire logic        converter_irq_enable_i, // interrupt enable bit
   input  wire logic        global_irq_enable_i,    // global enable bit
   input  wire logic        other_irq_i,        // any other interrupt request
   output logic      [2:0]  channel_select_o,   // multiplexer select
   output logic      [7:0]  pin_analog_select_o,// pin routed to multiplexer
   output logic             converter_on_o,     // converter powered
   output logic             cpu_halt_o,         // cpu stopped, peripherals run
   output logic             wake_o,             // wake the halted cpu
   output logic             conv_irq_o,         // end of conversion request
   output logic             other_irq_o         // other interrupts, held in pseudo idle
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [4:0] div_reg;
   logic [2:0] chan_reg;
   logic       start_reg;
   logic       done_reg;
   logic       on_reg;
   logic       pseudo_idle_select_reg;
   logic [7:0] pin_cfg_reg;
   logic [7:0] res_high_reg;
   logic [1:0] res_low_reg;
   logic       halt_reg;
   logic       ack_reg;
   logic [31:0] rdata_reg;
   logic [3:0] tick_cnt_reg;
   conv_pkg::conv_state_t state_reg;

   logic       wr_strobe;
   logic       wr_ctl;
   logic       start_req;
   logic       finish;
   logic [9:0] code;
   logic       sample_load;
   logic       sar_step;

   tick_if tk ();

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   // one wait state: ack one cycle after strobe, dropped the cycle after
   // sel[0] gates writes: only the low byte lane is mapped
   assign wr_strobe = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
   assign wr_ctl    = wr_strobe && (wb_adr_i == `OFS_CONTROL);

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      end
   end

   // read mux; unused bits read zero, permitted by indeterminate spec
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg) begin
         if (wb_adr_i == `OFS_CLK_DIV) begin
            rdata_reg <= {27'h0, div_reg}; // [RULE16]
         end else if (wb_adr_i == `OFS_CONTROL) begin
            rdata_reg <= {24'h0, `RESERVED_FILL, pseudo_idle_select_reg, on_reg, done_reg, start_reg,
                          chan_reg};
         end else if (wb_adr_i == `OFS_RES_LOW) begin
            rdata_reg <= {30'h0, res_low_reg}; // [RULE16] [RULE18]
         end else if (wb_adr_i == `OFS_RES_HIGH) begin
            rdata_reg <= {24'h0, res_high_reg}; // [RULE17]
         end else if (wb_adr_i == `OFS_PIN_CFG) begin
            rdata_reg <= {24'h0, pin_cfg_reg};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // ----------------------------------------
   // software written configuration
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         div_reg     <= 5'h00;
         pin_cfg_reg <= `RESET_BYTE;
      end else if (wr_strobe && wb_adr_i == `OFS_CLK_DIV) begin
         div_reg <= wb_dat_i[`DIV_HI:0];
      end else if (wr_strobe && wb_adr_i == `OFS_PIN_CFG) begin
         pin_cfg_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         chan_reg   <= 3'h0;
         on_reg     <= 1'b0;
         pseudo_idle_select_reg <= 1'b0;
      end else if (wr_ctl) begin
         chan_reg   <= wb_dat_i[`CTL_CH_HI:`CTL_CH_LO]; // [RULE1]
         on_reg     <= wb_dat_i[`CTL_ON];
         pseudo_idle_select_reg <= wb_dat_i[`CTL_PSEUDO_IDLE_SELECT];
      end
   end

   // ----------------------------------------
   // start and done flags
   // ----------------------------------------
   // software cannot cancel a running conversion by writing zero
   assign start_req = wr_ctl && wb_dat_i[`CTL_START] && !start_reg && on_reg;

   // a run cut by standby must not leave the busy bit stuck, or no start is taken again
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         start_reg <= 1'b0;
      end else if (finish || !on_reg) begin
         start_reg <= 1'b0; // [RULE3] [RULE10]
      end else if (start_req) begin
         start_reg <= 1'b1; // [RULE2]
      end
   end

   // set wins over a clear written in the same cycle
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         done_reg <= 1'b0;
      end else if (finish) begin
         done_reg <= 1'b1; // [RULE4]
      end else if (wr_ctl && !wb_dat_i[`CTL_DONE]) begin
         done_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   assign tk.run       = on_reg && start_reg; // [RULE10]
   assign tk.div_value = div_reg;

   conv_prescaler u_prescaler (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .tk      (tk)
   );

   // standby aborts the sequence, clock stops with it
   always_ff @(posedge clock_i) begin
      if (srst_i || !on_reg) begin
         state_reg    <= conv_pkg::st_idle;
         tick_cnt_reg <= 4'h0;
      end else begin
         case (state_reg)
            conv_pkg::st_idle: begin
               tick_cnt_reg <= 4'h0;
               if (start_req) begin
                  state_reg <= conv_pkg::st_sample;
               end
            end
            conv_pkg::st_sample: begin
               if (tk.tick) begin
                  tick_cnt_reg <= tick_cnt_reg + 4'h1;
                  state_reg    <= conv_pkg::st_convert;
               end
            end
            conv_pkg::st_convert: begin
               if (tk.tick) begin
                  tick_cnt_reg <= tick_cnt_reg + 4'h1;
                  if (tick_cnt_reg + 4'h1 == `CONV_TICKS) begin
                     state_reg <= conv_pkg::st_finish; // [RULE8]
                  end
               end
            end
            conv_pkg::st_finish: begin
               state_reg <= conv_pkg::st_idle;
            end
            default: begin
               state_reg <= conv_pkg::st_idle;
            end
         endcase
      end
   end

   // the prescaler may pulse once more as run drops; idle ignores it
   assign sample_load = (state_reg == conv_pkg::st_sample) && tk.tick;
   assign sar_step    = (state_reg == conv_pkg::st_convert) && tk.tick;
   assign finish      = (state_reg == conv_pkg::st_finish);

   // clamped level in, 000..3ff out, linear between
   conv_approx u_approx (
      .clock_i  (clock_i),
      .srst_i   (srst_i),
      .load_i   (sample_load),
      .step_i   (sar_step),
      .sample_i (converter_input_i), // [RULE6]
      .code_o   (code)
   );

   // ----------------------------------------
   // results
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         res_high_reg <= `RESET_BYTE;
         res_low_reg  <= 2'h0;
      end else if (finish) begin
         res_high_reg <= code[`RES_W-1:2]; // [RULE7] [RULE20]
         res_low_reg  <= code[1:0];        // [RULE7] [RULE20]
      end
   end

   // ----------------------------------------
   // pseudo idle and interrupts
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         halt_reg <= 1'b0;
      end else if (finish || !on_reg) begin
         halt_reg <= 1'b0;
      end else if (start_req && wb_dat_i[`CTL_PSEUDO_IDLE_SELECT]) begin
         halt_reg <= 1'b1; // [RULE12]
      end
   end

   assign cpu_halt_o  = halt_reg;
   assign conv_irq_o  = done_reg && converter_irq_enable_i && global_irq_enable_i; // [RULE5] [RULE19]
   assign wake_o      = halt_reg ? 1'b0 : conv_irq_o; // [RULE13]
   assign other_irq_o = other_irq_i && !halt_reg;  // [RULE14]

   assign channel_select_o    = chan_reg;
   assign pin_analog_select_o = pin_cfg_reg; // [RULE15]
   assign converter_on_o      = on_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_done_after_finish: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE4]
      finish |=> done_reg && !start_reg)
      else $error("done flag not set after finish");
   a_start_busy_hold: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE3]
      (state_reg != conv_pkg::st_idle) |-> start_reg)
      else $error("start bit dropped while busy");
   a_result_layout: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE7]
      finish |=> res_high_reg == $past(code[9:2]) && res_low_reg == $past(code[1:0]))
      else $error("result layout wrong");
   a_irq_gating: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE19]
      conv_irq_o |-> global_irq_enable_i && converter_irq_enable_i && done_reg)
      else $error("irq without enables");
   a_halt_holds_other: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE14]
      halt_reg |-> !other_irq_o)
      else $error("other irq passed in pseudo idle");
   a_standby_idle: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE10]
      !on_reg |=> state_reg == conv_pkg::st_idle)
      else $error("converter runs in standby");
   a_start_launch: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE2]
      start_req |=> state_reg == conv_pkg::st_sample && start_reg)
      else $error("start did not launch");
   a_results_stable: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE20]
      !$past(finish) |-> $stable(res_high_reg))
      else $error("result changed without finish");
   a_channel_decode: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE1]
      wr_ctl |=> channel_select_o == $past(wb_dat_i[2:0]))
      else $error("channel not taken");
   a_halt_release: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE12]
      finish |=> !cpu_halt_o)
      else $error("halt not released");

   // ----------------------------------------
   // flag, clock and routing checks
   // ----------------------------------------
   a_standby_clears: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE10]
      !on_reg |=> !start_reg && !cpu_halt_o)
      else $error("busy state kept in standby");
   a_start_refused_off: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE10]
      wr_ctl && !on_reg && !start_reg |=> !start_reg)
      else $error("start taken in standby");
   a_done_held: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE4]
      done_reg && !wr_ctl |=> done_reg)
      else $error("done flag lost without software clear");
   a_done_only_finish: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE4]
      !done_reg && !finish |=> !done_reg)
      else $error("done flag set without finish");
   a_conv_ticks: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE8]
      finish |-> tick_cnt_reg == `CONV_TICKS)
      else $error("conversion length wrong");

   // zero and one small value cover both prescaler branches
   a_zero_div_slow: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE9]
      tk.tick && div_reg == 5'h00 |=> !tk.tick [*8])
      else $error("zero prescaler setting too fast");
   a_div_two_period: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE9]
      tk.tick && tk.run && div_reg == 5'h02 |=> !tk.tick [*3] ##1 (tk.tick || !tk.run))
      else $error("converter clock period wrong");

   a_halt_needs_select: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE12]
      $rose(halt_reg) |-> pseudo_idle_select_reg && start_reg)
      else $error("halt without pseudo idle start");
   a_wake_on_finish: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE13]
      finish && converter_irq_enable_i && global_irq_enable_i |=>
         wake_o || !converter_irq_enable_i || !global_irq_enable_i)
      else $error("no wake at end of conversion");
   a_low_result_stable: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE20]
      !$past(finish) |-> $stable(res_low_reg))
      else $error("low result changed without finish");
   a_pin_route: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE15]
      wr_strobe && wb_adr_i == `OFS_PIN_CFG |=> pin_analog_select_o == $past(wb_dat_i[7:0]))
      else $error("pin routing not taken");
   a_ack_single: assert property (@(posedge clock_i) disable iff (srst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule

// >>> conv_defines.svh
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH

// register offsets (consecutive byte addresses, compared directly with wb_adr_i)
`define OFS_CLK_DIV     8'hf2
`define OFS_CONTROL     8'hf3
`define OFS_RES_LOW     8'hf4
`define OFS_RES_HIGH    8'hf5
`define OFS_PIN_CFG     8'hf6

// conv_control bit positions
`define CTL_CH_HI       2
`define CTL_CH_LO       0
`define CTL_START       3
`define CTL_DONE        4
`define CTL_ON          5
`define CTL_PSEUDO_IDLE_SELECT      6

// divider field, result width, tick counts and fill values
`define DIV_HI          4
`define DIV_ZERO_HALF   6'h20
`define RES_W           10
`define SAMPLE_TICKS    4'h1
`define CONV_TICKS      4'hb
`define RESET_BYTE      8'h00
`define RESERVED_FILL   1'b0

`endif

// >>> conv_pkg.sv
package conv_pkg;
   typedef enum logic [1:0] {
      st_idle,
      st_sample,
      st_convert,
      st_finish
   } conv_state_t;
endpackage

// >>> tick_if.sv
`timescale 1ns/1ns
interface tick_if;
   logic       run;
   logic [4:0] div_value;
   logic       tick;
   modport src (input run, input div_value, output tick);
   modport dst (output run, output div_value, input tick);
endinterface

// >>> conv_prescaler.sv
`timescale 1ns/1ns
`include "conv_defines.svh"
module conv_prescaler (
   input  wire logic clock_i,       // system clock
   input  wire logic srst_i,        // sync reset
   tick_if.src       tk             // tick request/answer
);
   logic [5:0] half_reg;
   logic [5:0] cnt_reg;
   logic       tick_reg;

   // zero means divide by 64, else divide by 2*value; tick once per period
   always_comb begin
      if (tk.div_value == 5'h00) begin
         half_reg = `DIV_ZERO_HALF; // [RULE9]
      end else begin
         half_reg = {1'b0, tk.div_value};
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i || !tk.run) begin
         cnt_reg  <= 6'h00;
         tick_reg <= 1'b0;
      end else if ({1'b0, cnt_reg} + 7'h01 >= {half_reg, 1'b0}) begin
         cnt_reg  <= 6'h00;
         tick_reg <= 1'b1;
      end else begin
         cnt_reg  <= cnt_reg + 6'h01;
         tick_reg <= 1'b0;
      end
   end

   assign tk.tick = tick_reg;
endmodule

// >>> conv_approx.sv
`timescale 1ns/1ns
`include "conv_defines.svh"
module conv_approx (
   input  wire logic        clock_i,     // system clock
   input  wire logic        srst_i,      // sync reset
   input  wire logic        load_i,      // capture sample
   input  wire logic        step_i,      // one bit decision
   input  wire logic [9:0]  sample_i,    // digitised input level
   output logic      [9:0]  code_o       // running approximation
);
   logic [9:0] held_reg;
   logic [9:0] trial_reg;
   logic [9:0] code_reg;

   // binary search, msb first; inputs beyond the rails already clamp upstream
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         held_reg  <= 10'h000;
         trial_reg <= 10'h000;
         code_reg  <= 10'h000;
      end else if (load_i) begin
         held_reg  <= sample_i;
         trial_reg <= 10'h200;
         code_reg  <= 10'h000;
      end else if (step_i && trial_reg != 10'h000) begin
         if ((code_reg | trial_reg) <= held_reg) begin
            code_reg <= code_reg | trial_reg;
         end
         trial_reg <= trial_reg >> 1;
      end
   end

   assign code_o = code_reg;
endmodule

// >>> analog_front_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// eight analog inputs behind one multiplexer
// ----------------------------------------
module analog_front_model (
   input  wire logic [79:0] levels_i,            // eight 10-bit levels, input 0 lowest
   input  wire logic [2:0]  channel_select_i,    // multiplexer select
   input  wire logic [7:0]  pin_analog_select_i, // pins routed to the multiplexer
   output logic      [9:0]  converter_input_o    // level seen by the converter
);
   logic [9:0] picked;

   // levels arrive already clamped to 000..3ff, linear in between
   assign picked = levels_i[channel_select_i * 10 +: 10];
   // a pin left as general i/o never reaches the converter: show garbage
   assign converter_input_o = pin_analog_select_i[channel_select_i] ? picked : ~picked;
endmodule

// >>> tb_adc_sequencing_control.sv
`timescale 1ns/1ns
module tb_adc_sequencing_control;
   logic        clock_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i, pin_analog_select_o;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [9:0]  converter_input_i;
   logic        converter_irq_enable_i, global_irq_enable_i, other_irq_i;
   logic [2:0]  channel_select_o;
   logic        converter_on_o, cpu_halt_o, wake_o, conv_irq_o, other_irq_o;
   logic [79:0] levels;
   logic [15:0] rng;
   logic [32:0] expq [$];
   logic [32:0] ent;
   logic [31:0] dummy;
   int          errors, samples_checked;

   adc_sequencing_control u_dut (.clock_i(clock_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .converter_input_i(converter_input_i), .converter_irq_enable_i(converter_irq_enable_i),
      .global_irq_enable_i(global_irq_enable_i), .other_irq_i(other_irq_i),
      .channel_select_o(channel_select_o), .pin_analog_select_o(pin_analog_select_o),
      .converter_on_o(converter_on_o), .cpu_halt_o(cpu_halt_o), .wake_o(wake_o),
      .conv_irq_o(conv_irq_o), .other_irq_o(other_irq_o));

   analog_front_model u_front (.levels_i(levels), .channel_select_i(channel_select_o),
      .pin_analog_select_i(pin_analog_select_o), .converter_input_o(converter_input_i));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         errors++;
      end
   endtask

   task automatic report_and_stop;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one classic cycle; ack sampled on rising edges, data taken and request dropped there
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      input logic chk, input logic [31:0] exp, output logic [31:0] rdat);
      int n;
      n = 0;
      if (!we)
         expq.push_back({chk, exp});
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h1;
      wb_dat_i <= wd;
      do begin
         @(posedge clock_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rdat = wb_dat_o;
      if (n >= 50)
         errors++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      bus(1'b1, adr, {24'h000000, d}, 1'b0, 32'h00000000, dummy);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
      bus(1'b0, adr, 32'h00000000, 1'b1, {24'h000000, exp}, dummy);
   endtask

   // prescaler value dv gives 2*dv cycles a converter clock, 64 when zero
   task automatic convert(input logic [2:0] ch, input logic [4:0] dv);
      int          span;
      int          n;
      logic [31:0] d;
      logic        ps;
      logic        ie;
      logic        ge;
      span = ((dv == 5'h00) ? 64 : 2 * dv) * 11 - 8;
      ps = ch[2];
      ie = ch[0] | ps;
      ge = ch[1] | ps;
      n = 0;
      d = 32'h00000000;
      converter_irq_enable_i <= ie;
      global_irq_enable_i    <= ge;
      other_irq_i            <= 1'b1;
      wr(8'hf2, {3'h0, dv}); // upper bits left zero
      wr(8'hf3, {5'h04, ch});
      check({29'h0, channel_select_o}, {29'h0, ch});
      wr(8'hf3, {1'b0, ps, 3'b101, ch});
      rd_chk(8'hf3, {1'b0, ps, 3'b101, ch});
      check({31'h0, cpu_halt_o}, {31'h0, ps});
      check({31'h0, wake_o}, 32'h00000000);
      check({31'h0, other_irq_o}, {31'h0, ~ps});
      repeat (span) @(posedge clock_i);
      rd_chk(8'hf3, {1'b0, ps, 3'b101, ch});
      while (d[4] !== 1'b1 && n < 200) begin
         bus(1'b0, 8'hf3, 32'h00000000, 1'b0, 32'h00000000, d);
         n++;
      end
      check({31'h0, n <= 3}, 32'h00000001);
      check(d, {24'h0, 1'b0, ps, 3'b110, ch});
      rd_chk(8'hf5, levels[ch * 10 + 2 +: 8]);
      rd_chk(8'hf4, {6'h00, levels[ch * 10 +: 2]});
      check({31'h0, conv_irq_o}, {31'h0, ie & ge});
      check({31'h0, wake_o}, {31'h0, ie & ge});
      check({31'h0, cpu_halt_o}, 32'h00000000);
      check({31'h0, other_irq_o}, 32'h00000001);
      wr(8'hf3, {5'h04, ch});
      rd_chk(8'hf3, {5'h04, ch});
      check({31'h0, conv_irq_o}, 32'h00000000);
   endtask

   // ----------------------------------------
   // read results are noted in order and compared when ack shows
   // ----------------------------------------
   always @(posedge clock_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
         ent = expq.pop_front();
         if (ent[32])
            check(wb_dat_o, ent[31:0]);
      end
   end

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   initial begin
      repeat (60000) @(posedge clock_i);
      errors++;
      report_and_stop;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      srst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      converter_irq_enable_i = 1'b0;
      global_irq_enable_i = 1'b0;
      other_irq_i = 1'b0;
      rng = 16'h0012;
      levels = 80'h0;
      errors = 0;
      samples_checked = 0;
      repeat (16) @(posedge clock_i);
      srst_i <= 1'b0;
      for (int a = 0; a < 6; a++)
         rd_chk(8'hf2 + a[7:0], 8'h00);
      wr(8'hf5, 8'hff);
      wr(8'hf4, 8'h03);
      rd_chk(8'hf5, 8'h00);
      rd_chk(8'hf4, 8'h00);
      rng = lfsr(rng);
      wr(8'hf6, rng[7:0]);
      rd_chk(8'hf6, rng[7:0]);
      check({24'h0, pin_analog_select_o}, {24'h0, rng[7:0]});
      wr(8'hf6, 8'hff);
      wr(8'hf3, 8'h08);
      rd_chk(8'hf3, 8'h00);
      check({31'h0, converter_on_o}, 32'h00000000);
      wr(8'hf3, 8'h20);
      check({31'h0, converter_on_o}, 32'h00000001);
      for (int k = 1; k < 7; k++) begin
         rng = lfsr(rng);
         levels[k * 10 +: 10] <= rng[9:0];
      end
      levels[79:70] <= 10'h3ff;
      // settle time after enabling the converter, 4 us at 4 ns
      repeat (1000) @(posedge clock_i);
      for (int c = 0; c < 8; c++)
         convert(c[2:0], c[4:0] + 5'h01);
      convert(3'h5, 5'h00);
      // standby in mid conversion, then a fresh start must still be taken
      wr(8'hf3, 8'h2d);
      wr(8'hf3, 8'h05);
      rd_chk(8'hf3, 8'h05);
      wr(8'hf3, 8'h25);
      repeat (1000) @(posedge clock_i);
      wr(8'hf3, 8'h2d);
      rd_chk(8'hf3, 8'h2d);
      report_and_stop;
   end
endmodule
